// ---- src/fcsq_bus_cycle.sv ----
`default_nettype none
// runs one asynchronous bus cycle: set-up, strobe low, release
module fcsq_bus_cycle
    import fcsq_pkg::*;
(
    // clock and reset
    input  wire logic           i_ref_clk,
    input  wire logic           i_arst_n,
    // cycle request
    fcsq_cyc_if.eng             cyc,
    // flash pins
    input  wire logic [FCSQ_DATA_W-1:0] i_dq,
    output var  logic [FCSQ_DATA_W-1:0] o_dq,
    output var  logic           o_dq_oe,
    output var  logic [FCSQ_ADDR_W-1:0] o_addr,
    output var  logic           o_ce_n,
    output var  logic           o_we_n,
    output var  logic           o_oe_n
);
    typedef enum logic [3:0] {
        FCSQ_BC_IDLE  = 4'b0001,
        FCSQ_BC_SETUP = 4'b0010,
        FCSQ_BC_PULSE = 4'b0100,
        FCSQ_BC_DONE  = 4'b1000
    } fcsq_bc_e;

    fcsq_bc_e   st_q;
    logic [3:0] cnt_q;
    logic       wr_q;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q   <= FCSQ_BC_IDLE;
            cnt_q  <= 4'h0;
            wr_q   <= 1'b0;
            o_addr <= '0;
            o_dq   <= '0;
            o_dq_oe <= 1'b0;
            o_ce_n <= 1'b1;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            cyc.done  <= 1'b0;
            cyc.rdata <= '0;
        end else begin
            cyc.done <= 1'b0;
            unique case (st_q)
                FCSQ_BC_IDLE: if (cyc.req) begin
                    st_q    <= FCSQ_BC_SETUP;
                    wr_q    <= cyc.wr;
                    o_addr  <= cyc.addr;
                    o_dq    <= cyc.wdata;
                    o_dq_oe <= cyc.wr;
                    o_ce_n  <= 1'b0;
                    cnt_q   <= 4'(FCSQ_SETUP_CYC);
                end
                FCSQ_BC_SETUP: begin
                    if (cnt_q <= 4'h1) begin
                        st_q   <= FCSQ_BC_PULSE;
                        o_we_n <= !wr_q;
                        o_oe_n <= wr_q;
                        cnt_q  <= wr_q ? 4'(FCSQ_PULSE_CYC)
                                       : 4'(FCSQ_ACCESS_CYC);
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                FCSQ_BC_PULSE: begin
                    if (cnt_q <= 4'h1) begin
                        st_q      <= FCSQ_BC_DONE;
                        o_we_n    <= 1'b1;
                        o_oe_n    <= 1'b1;
                        cyc.rdata <= i_dq;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                FCSQ_BC_DONE: begin
                    st_q     <= FCSQ_BC_IDLE;
                    o_ce_n   <= 1'b1;
                    o_dq_oe  <= 1'b0;
                    cyc.done <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- src/fcsq_cyc_if.sv ----
`default_nettype none
interface fcsq_cyc_if;
    import fcsq_pkg::*;
    logic                   req;
    logic                   wr;
    logic [FCSQ_ADDR_W-1:0] addr;
    logic [FCSQ_DATA_W-1:0] wdata;
    logic                   done;
    logic [FCSQ_DATA_W-1:0] rdata;
    modport ctl (output req, wr, addr, wdata, input done, rdata);
    modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ---- src/fcsq_pkg.sv ----
// Function
// - command cycles are writes; plain reads and id fourth cycle are reads.
// - unlock addresses 555h/2aah in word mode, aaah/555h in byte mode.
// - id entry is aah@555h, 55h@2aah, 90h@555h, then a read returns code.
// - reset command leaves id mode and clears timing-exceeded status.
// - program is two unlocks, a0h set-up, then target address and data.
// - chip erase is six writes ending with 10h at 555h.
`default_nettype none
package fcsq_pkg;
    localparam logic [11:0] FCSQ_ADDR_UNLK1_W = 12'h555;
    localparam logic [11:0] FCSQ_ADDR_UNLK2_W = 12'h2aa;
    localparam logic [11:0] FCSQ_ADDR_UNLK1_B = 12'haaa;
    localparam logic [11:0] FCSQ_ADDR_UNLK2_B = 12'h555;
    localparam logic [7:0]  FCSQ_DAT_UNLK1    = 8'haa;
    localparam logic [7:0]  FCSQ_DAT_UNLK2    = 8'h55;
    localparam logic [7:0]  FCSQ_CMD_PROG     = 8'ha0;
    localparam logic [7:0]  FCSQ_CMD_ERASE    = 8'h80;
    localparam logic [7:0]  FCSQ_CMD_CHIP     = 8'h10;
    localparam logic [7:0]  FCSQ_CMD_RESET    = 8'hf0;
    localparam logic [7:0]  FCSQ_CMD_IDENT    = 8'h90;
    localparam logic [7:0]  FCSQ_CMD_SUSPEND  = 8'hb0;
    localparam logic [7:0]  FCSQ_CMD_RESUME   = 8'h30;
    localparam logic [7:0]  FCSQ_OFS_MAKER    = 8'h00;
    localparam logic [7:0]  FCSQ_OFS_DEVICE   = 8'h01;
    localparam logic [7:0]  FCSQ_OFS_PROTECT  = 8'h02;
    localparam int          FCSQ_ADDR_W       = 18;
    localparam int          FCSQ_DATA_W       = 16;
    // bus cycle timing in ns, rounded up to whole clock cycles
    localparam int          FCSQ_T_SETUP_NS   = 50;
    localparam int          FCSQ_T_PULSE_NS   = 100;
    localparam int          FCSQ_T_ACCESS_NS  = 100;
    localparam int          FCSQ_CLK_NS       = 50;
    localparam int          FCSQ_SETUP_CYC    =
        (FCSQ_T_SETUP_NS + FCSQ_CLK_NS - 1) / FCSQ_CLK_NS;
    localparam int          FCSQ_PULSE_CYC    =
        (FCSQ_T_PULSE_NS + FCSQ_CLK_NS - 1) / FCSQ_CLK_NS;
    localparam int          FCSQ_ACCESS_CYC   =
        (FCSQ_T_ACCESS_NS + FCSQ_CLK_NS - 1) / FCSQ_CLK_NS;

    typedef enum logic [3:0] {
        FCSQ_OP_READ    = 4'h0,
        FCSQ_OP_RESET   = 4'h1,
        FCSQ_OP_PROG    = 4'h2,
        FCSQ_OP_CHIP    = 4'h3,
        FCSQ_OP_IDREAD  = 4'h4,
        FCSQ_OP_SUSPEND = 4'h5,
        FCSQ_OP_RESUME  = 4'h6
    } fcsq_op_e;
endpackage
`default_nettype wire

// ---- src/fcsq_top.sv ----
`default_nettype none
// host-side sequencer: turns one operation into its command bus cycles
module fcsq_top
    import fcsq_pkg::*;
(
    // clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_arst_n,
    // operation request
    input  wire logic                   i_op_valid,
    input  wire logic [3:0]             i_op,
    input  wire logic                   i_byte_mode,
    input  wire logic [FCSQ_ADDR_W-1:0] i_addr,
    input  wire logic [FCSQ_DATA_W-1:0] i_wdata,
    output logic                        o_op_ready,
    output logic                        o_op_done,
    output logic [FCSQ_DATA_W-1:0]      o_rdata,
    // flash pins
    input  wire logic [FCSQ_DATA_W-1:0] i_dq,
    output logic [FCSQ_DATA_W-1:0]      o_dq,
    output logic                        o_dq_oe,
    output logic [FCSQ_ADDR_W-1:0]      o_addr,
    output logic                        o_ce_n,
    output logic                        o_we_n,
    output logic                        o_oe_n,
    output logic                        o_flash_rst_n
);
    typedef enum logic [3:0] {
        FCSQ_S_IDLE  = 4'b0001,
        FCSQ_S_ISSUE = 4'b0010,
        FCSQ_S_WAIT  = 4'b0100,
        FCSQ_S_FIN   = 4'b1000
    } fcsq_st_e;

    fcsq_cyc_if cyc ();

    fcsq_bus_cycle fcsq_bus_cycle_inst (
        .i_ref_clk (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .cyc       (cyc.eng),
        .i_dq      (i_dq),
        .o_dq      (o_dq),
        .o_dq_oe   (o_dq_oe),
        .o_addr    (o_addr),
        .o_ce_n    (o_ce_n),
        .o_we_n    (o_we_n),
        .o_oe_n    (o_oe_n)
    );

    fcsq_st_e               st_q;
    fcsq_op_e               op_q;
    logic                   byte_q;
    logic [2:0]             idx_q;
    logic [2:0]             len_q;
    logic [FCSQ_ADDR_W-1:0] tgt_q;
    logic [FCSQ_DATA_W-1:0] dat_q;
    logic [11:0]            a1;
    logic [11:0]            a2;
    logic [FCSQ_ADDR_W-1:0] step_addr;
    logic [FCSQ_DATA_W-1:0] step_data;
    logic                   step_wr;
    logic [2:0]             op_len;

    // unlock address pair follows the bus width; upper bits left zero
    always_comb begin
        a1 = byte_q ? FCSQ_ADDR_UNLK1_B : FCSQ_ADDR_UNLK1_W;
        a2 = byte_q ? FCSQ_ADDR_UNLK2_B : FCSQ_ADDR_UNLK2_W;
    end

    // cycle count of each operation
    always_comb begin
        unique case (fcsq_op_e'(i_op))
            FCSQ_OP_PROG:   op_len = 3'd4;
            FCSQ_OP_CHIP:   op_len = 3'd6;
            FCSQ_OP_IDREAD: op_len = 3'd4;
            default:        op_len = 3'd1;
        endcase
    end

    // address, data and direction of the current step
    always_comb begin
        step_wr   = 1'b1;
        step_addr = {6'h00, a1};
        step_data = {8'h00, FCSQ_DAT_UNLK1};
        unique case (op_q)
            FCSQ_OP_READ: begin
                step_wr   = 1'b0;
                step_addr = tgt_q;
            end
            FCSQ_OP_RESET: begin
                step_addr = tgt_q;
                step_data = {8'h00, FCSQ_CMD_RESET};
            end
            FCSQ_OP_SUSPEND: begin
                step_addr = tgt_q;
                step_data = {8'h00, FCSQ_CMD_SUSPEND};
            end
            FCSQ_OP_RESUME: begin
                step_addr = tgt_q;
                step_data = {8'h00, FCSQ_CMD_RESUME};
            end
            default: begin
                unique case (idx_q)
                    3'd0, 3'd3: begin
                        step_addr = {6'h00, a1};
                        step_data = {8'h00, FCSQ_DAT_UNLK1};
                    end
                    3'd1, 3'd4: begin
                        step_addr = {6'h00, a2};
                        step_data = {8'h00, FCSQ_DAT_UNLK2};
                    end
                    default: begin
                        step_addr = {6'h00, a1};
                        step_data = {8'h00, FCSQ_CMD_CHIP};
                    end
                endcase
                if (idx_q == 3'd2) begin
                    unique case (op_q)
                        FCSQ_OP_PROG:
                            step_data = {8'h00, FCSQ_CMD_PROG};
                        FCSQ_OP_CHIP:
                            step_data = {8'h00, FCSQ_CMD_ERASE};
                        default:
                            step_data = {8'h00, FCSQ_CMD_IDENT};
                    endcase
                end
                if (idx_q == 3'd3 && op_q == FCSQ_OP_PROG) begin
                    step_addr = tgt_q;
                    step_data = dat_q;
                end
                if (idx_q == 3'd3 && op_q == FCSQ_OP_IDREAD) begin
                    step_wr   = 1'b0;
                    step_addr = tgt_q;
                end
            end
        endcase
    end

    // sequencer
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q   <= FCSQ_S_IDLE;
            op_q   <= FCSQ_OP_READ;
            byte_q <= 1'b0;
            idx_q  <= 3'd0;
            len_q  <= 3'd1;
            tgt_q  <= '0;
            dat_q  <= '0;
        end else begin
            unique case (st_q)
                FCSQ_S_IDLE: if (i_op_valid) begin
                    st_q   <= FCSQ_S_ISSUE;
                    op_q   <= fcsq_op_e'(i_op);
                    byte_q <= i_byte_mode;
                    tgt_q  <= i_addr;
                    dat_q  <= i_wdata;
                    idx_q  <= 3'd0;
                    len_q  <= op_len;
                end
                FCSQ_S_ISSUE: st_q <= FCSQ_S_WAIT;
                FCSQ_S_WAIT: if (cyc.done) begin
                    if (idx_q + 3'd1 == len_q) begin
                        st_q <= FCSQ_S_FIN;
                    end else begin
                        idx_q <= idx_q + 3'd1;
                        st_q  <= FCSQ_S_ISSUE;
                    end
                end
                FCSQ_S_FIN: st_q <= FCSQ_S_IDLE;
            endcase
        end
    end

    // bus cycle request, registered: high for the one cycle after the issue state
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cyc.req   <= 1'b0;
            cyc.wr    <= 1'b0;
            cyc.addr  <= '0;
            cyc.wdata <= '0;
        end else begin
            cyc.req   <= (st_q == FCSQ_S_ISSUE);
            cyc.wr    <= step_wr;
            cyc.addr  <= step_addr;
            cyc.wdata <= step_data;
        end
    end

    // answer side
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_op_ready    <= 1'b0;
            o_op_done     <= 1'b0;
            o_rdata       <= '0;
            o_flash_rst_n <= 1'b0;
        end else begin
            o_flash_rst_n <= 1'b1;
            o_op_ready    <= (st_q == FCSQ_S_IDLE) && !i_op_valid;
            o_op_done     <= (st_q == FCSQ_S_FIN);
            if (st_q == FCSQ_S_WAIT && cyc.done && !cyc.wr) begin
                o_rdata <= cyc.rdata;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/fcsq_checker.sv ----
`default_nettype none
module fcsq_checker
    import fcsq_pkg::*;
(
    // clock, reset and handshake
    input wire logic                   i_ref_clk,
    input wire logic                   i_arst_n,
    input wire logic                   i_op_valid,
    input wire logic                   o_op_ready,
    input wire logic                   o_op_done,
    // flash pins
    input wire logic                   o_dq_oe,
    input wire logic [FCSQ_ADDR_W-1:0] o_addr,
    input wire logic                   o_ce_n,
    input wire logic                   o_we_n,
    input wire logic                   o_oe_n,
    input wire logic                   o_flash_rst_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    rw_excl_a: assert property (!(!o_we_n && !o_oe_n))
        else $error("write and read strobes low together");
    wr_drive_a: assert property (!o_we_n |-> !o_ce_n && o_dq_oe)
        else $error("write strobe without select or data drive");
    rd_float_a: assert property (!o_oe_n |-> !o_ce_n && !o_dq_oe)
        else $error("read strobe with data driven");
    we_width_a: assert property ($fell(o_we_n) |=> !o_we_n ##1 o_we_n)
        else $error("write strobe not two cycles");
    addr_hold_a: assert property (
        !o_we_n || !o_oe_n |-> $stable(o_addr))
        else $error("address moved under strobe");
    done_one_a: assert property (o_op_done |=> !o_op_done)
        else $error("done longer than one cycle");
    take_busy_a: assert property (
        i_op_valid && o_op_ready |=> !o_op_ready ##1 !o_op_ready)
        else $error("ready after a taken request");
    frst_hi_a: assert property ($past(i_arst_n) |-> o_flash_rst_n)
        else $error("flash reset low outside reset");
endmodule

bind fcsq_top fcsq_checker fcsq_checker_inst (
    .i_ref_clk, .i_arst_n, .i_op_valid, .o_op_ready, .o_op_done,
    .o_dq_oe, .o_addr, .o_ce_n, .o_we_n, .o_oe_n, .o_flash_rst_n
);
`default_nettype wire

// ---- verif/fcsq_flash_model.sv ----
`default_nettype none
module fcsq_flash_model
    import fcsq_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h00c5, // arbitrary value
    parameter logic [15:0] DEV_CODE   = 16'h5a01  // arbitrary value
)(
    // bus pins
    input  wire logic [17:0] i_addr,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_rst_n,
    input  wire logic        i_byte_mode,
    output wire logic [15:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [16];
    logic [17:0] wa [$];
    logic [15:0] wd [$];
    logic [2:0]  k = 3'h0;
    logic        id = 1'b0;
    logic [15:0] idv;
    logic [15:0] v_q = 16'h0000;
    wire  [11:0] u = i_byte_mode ? i_addr[11:0]
                                 : {1'b0, i_addr[10:0]};
    wire  [11:0] u1 = i_byte_mode ? FCSQ_ADDR_UNLK1_B : FCSQ_ADDR_UNLK1_W;
    wire  [11:0] u2 = i_byte_mode ? FCSQ_ADDR_UNLK2_B : FCSQ_ADDR_UNLK2_W;
    wire  [7:0]  c = i_dq[7:0];
    wire  [15:0] v = id ? idv : mem[i_addr[3:0]];
    // released bus shows the inverse of the last read value
    assign o_dq = (!i_ce_n && !i_oe_n) ? v : ~v_q;
    initial foreach (mem[i]) mem[i] = 16'hffff;
    always @(posedge i_oe_n) v_q = v;
    always @* begin
        case (i_addr[7:0])
            8'h00, 8'h04, 8'h08, 8'h0c: idv = MAKER_CODE;
            8'h01:   idv = DEV_CODE;
            8'h02:   idv = {15'h0000, i_addr[17]};
            default: idv = 16'h0000;
        endcase
    end
    always @(posedge i_we_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            k = 3'h0;
            id = 1'b0;
        end else if (!i_ce_n) begin
            wa.push_back(i_addr);
            wd.push_back(i_dq);
            if (c == FCSQ_CMD_RESET) begin
                k = 3'h0;
                id = 1'b0;
            end else if (k == 3'h3) begin
                mem[i_addr[3:0]] = mem[i_addr[3:0]] & i_dq;
                k = 3'h0;
            end else if (k == 3'h6 && u == u1 && c == FCSQ_CMD_CHIP) begin
                foreach (mem[i]) mem[i] = 16'hffff;
                k = 3'h0;
            end else if (k == 3'h2 && u == u1 && c == FCSQ_CMD_IDENT) begin
                id = 1'b1;
                k = 3'h0;
            end else if (k == 3'h2 && u == u1 && c == FCSQ_CMD_PROG)
                k = 3'h3;
            else if (k == 3'h2 && u == u1 && c == FCSQ_CMD_ERASE)
                k = 3'h4;
            else if ((k == 3'h0 || k == 3'h4) && u == u1 && c == 8'haa)
                k = k + 3'h1;
            else if ((k == 3'h1 || k == 3'h5) && u == u2 && c == 8'h55)
                k = k + 3'h1;
            else
                k = 3'h0;
        end
    end
endmodule
`default_nettype wire

// ---- verif/fcsq_top_tb.sv ----
`default_nettype none
module fcsq_top_tb
    import fcsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] MK = 16'h00c5; // arbitrary value
    localparam logic [15:0] DV = 16'h5a01; // arbitrary value
    logic        clk = 0, arst_n = 0, vld = 0, bm = 0;
    logic [3:0]  opc = 4'h0;
    logic [17:0] addr = 18'h00000, fa;
    logic [15:0] wdata = 16'h0000, rdata, dqi, dqo;
    logic        rdy, done, dqoe, ce_n, we_n, oe_n, frst_n;
    logic [17:0] ea [$];
    logic [15:0] ed [$];
    int          fails = 0, samples_checked = 0;
    always #25 clk = ~clk;
    fcsq_top fcsq_top_inst (.i_ref_clk(clk), .i_arst_n(arst_n),
        .i_op_valid(vld), .i_op(opc), .i_byte_mode(bm), .i_addr(addr),
        .i_wdata(wdata), .o_op_ready(rdy), .o_op_done(done),
        .o_rdata(rdata), .i_dq(dqi), .o_dq(dqo), .o_dq_oe(dqoe),
        .o_addr(fa), .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n),
        .o_flash_rst_n(frst_n));
    fcsq_flash_model #(.MAKER_CODE(MK), .DEV_CODE(DV))
        fcsq_flash_model_inst (.i_addr(fa), .i_dq(dqo), .i_ce_n(ce_n),
        .i_we_n(we_n), .i_oe_n(oe_n), .i_rst_n(frst_n),
        .i_byte_mode(bm), .o_dq(dqi));
    task automatic chk16(input string n, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk18(input string n, input logic [17:0] e, g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [17:0] u1();
        return {6'h00, bm ? FCSQ_ADDR_UNLK1_B : FCSQ_ADDR_UNLK1_W};
    endfunction
    task automatic ex(input logic [17:0] a, input logic [15:0] d);
        ea.push_back(a);
        ed.push_back(d);
    endtask
    task automatic ul();
        ex(u1(), 16'h00aa);
        ex({6'h00, bm ? FCSQ_ADDR_UNLK2_B : FCSQ_ADDR_UNLK2_W}, 16'h0055);
    endtask
    task automatic start(input logic [3:0] c, input logic [17:0] a,
                         input logic [15:0] d);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk16("op ready", 16'h0001, {15'h0000, rdy});
        fcsq_flash_model_inst.wa.delete();
        fcsq_flash_model_inst.wd.delete();
        vld = 1;
        opc = c;
        addr = a;
        wdata = d;
        @(negedge clk);
        vld = 0;
    endtask
    task automatic op(input logic [3:0] c, input logic [17:0] a,
                      input logic [15:0] d);
        int n;
        start(c, a, d);
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk16("op done", 16'h0001, {15'h0000, done});
    endtask
    task automatic cmp_log();
        logic [15:0] g;
        chk16("writes", 16'(ed.size()),
              16'(fcsq_flash_model_inst.wd.size()));
        foreach (ed[i]) if (i < fcsq_flash_model_inst.wd.size()) begin
            g = fcsq_flash_model_inst.wd[i];
            if (ed[i][15:8] == 8'h00) g = {8'h00, g[7:0]};
            chk18("write addr", ea[i], fcsq_flash_model_inst.wa[i]);
            chk16("write data", ed[i], g);
        end
        ea.delete();
        ed.delete();
    endtask
    task automatic t_prog(input logic b);
        logic [17:0] a;
        a = 18'h20006 | 18'(b);
        bm = b;
        ul();
        ex(u1(), {8'h00, FCSQ_CMD_PROG});
        ex(a, 16'h1234);
        op(FCSQ_OP_PROG, a, 16'h1234);
        cmp_log();
        op(FCSQ_OP_READ, a, 16'h0000);
        chk16("read data", 16'h1234, rdata);
        op(FCSQ_OP_PROG, a, 16'hff0f);
        op(FCSQ_OP_READ, a, 16'h0000);
        chk16("read data", 16'h1204, rdata);
    endtask
    task automatic t_chip();
        bm = 0;
        ul();
        ex(u1(), {8'h00, FCSQ_CMD_ERASE});
        ul();
        ex(u1(), {8'h00, FCSQ_CMD_CHIP});
        op(FCSQ_OP_CHIP, 18'h00000, 16'h0000);
        cmp_log();
        op(FCSQ_OP_READ, 18'h20006, 16'h0000);
        chk16("read data", 16'hffff, rdata);
    endtask
    task automatic t_id();
        logic [17:0] a [7] = '{18'h0, 18'h4, 18'h8, 18'hc, 18'h1,
                               18'h2, 18'h20002};
        logic [15:0] e [7] = '{MK, MK, MK, MK, DV, 16'h0000, 16'h0001};
        foreach (a[i]) begin
            ul();
            ex(u1(), {8'h00, FCSQ_CMD_IDENT});
            op(FCSQ_OP_IDREAD, a[i], 16'h0000);
            cmp_log();
            chk16("id data", e[i], rdata);
        end
        ex(18'h3ffff, {8'h00, FCSQ_CMD_RESET});
        op(FCSQ_OP_RESET, 18'h3ffff, 16'h0000);
        cmp_log();
        op(FCSQ_OP_READ, 18'h00001, 16'h0000);
        chk16("read data", 16'hffff, rdata);
    endtask
    task automatic t_misc();
        ex(18'h00123, {8'h00, FCSQ_CMD_SUSPEND});
        op(FCSQ_OP_SUSPEND, 18'h00123, 16'h0000);
        cmp_log();
        ex(18'h00321, {8'h00, FCSQ_CMD_RESUME});
        op(FCSQ_OP_RESUME, 18'h00321, 16'h0000);
        cmp_log();
    endtask
    task automatic t_hwrst();
        start(FCSQ_OP_PROG, 18'h0000a, 16'h0000);
        repeat (10) @(negedge clk);
        arst_n = 0;
        @(negedge clk);
        chk16("flash reset", 16'h0000, {15'h0000, frst_n});
        arst_n = 1;
        op(FCSQ_OP_READ, 18'h0000a, 16'h0000);
        chk16("read data", 16'hffff, rdata);
    endtask
    initial begin
        #500000;
        fails++;
        results();
    end
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1;
        @(negedge clk);
        t_prog(1'b0);
        t_prog(1'b1);
        t_chip();
        t_id();
        t_misc();
        t_hwrst();
        results();
    end
endmodule
`default_nettype wire
